/* File: verilog/fpp_cfg.svh */
`ifndef FPP_CFG_SVH
`define FPP_CFG_SVH

// register offsets
`define FPP_OFF_PWREG 8'hBB
`define FPP_OFF_STAT 8'hBC

// password register layout
`define FPP_PASS_MSB 7
`define FPP_PASS_LSB 3
`define FPP_PROT_BIT 2
`define FPP_MODE_MSB 1
`define FPP_MODE_LSB 0

// password register field resets, together 8'h07
`define FPP_PASS_RST 5'h00
`define FPP_PROT_RST 1'h1
`define FPP_MODE_RST 2'h3

// mode field bits
`define FPP_MODE_PFL_PE 0
`define FPP_MODE_DFL_PE 1

// password coding
`define FPP_PWD_NONE 16'hFFFF
`define FPP_PWD_HW_BIT 13
`define FPP_PWD_MSB 15
`define FPP_BL_MODE_INSTALL 4'h6

`endif

/* File: verilog/fpp_pkg.sv */
`include "fpp_cfg.svh"

package fpp_pkg;

	typedef enum logic [1:0] {
		FPP_OP_READ,
		FPP_OP_PROG,
		FPP_OP_ERASE
	} fpp_op_t;

	typedef enum logic [1:0] {
		FPP_AREA_PFLASH,
		FPP_AREA_DFLASH,
		FPP_AREA_OTHER
	} fpp_area_t;

	typedef enum logic [1:0] {
		FPP_HW_NONE,
		FPP_HW_MODE0,
		FPP_HW_MODE1
	} fpp_hwmode_t;

	// one flash access: kind, fetch area of the code, target area
	typedef struct packed {
		fpp_op_t op;
		fpp_area_t src;
		fpp_area_t target;
		logic [15:0] addr;
		logic [7:0] wdata;
	} fpp_req_t;

	function automatic fpp_hwmode_t fpp_decode_hw(input logic [15:0] pwd);
		fpp_hwmode_t m;
		m = FPP_HW_NONE;
		if (pwd[`FPP_PWD_HW_BIT]) begin
			m = pwd[`FPP_PWD_MSB] ? FPP_HW_MODE1 : FPP_HW_MODE0;
		end
		return m;
	endfunction

endpackage

/* File: verilog/fpp_access_check.sv */
`timescale 1ns/1ps
`include "fpp_cfg.svh"

module fpp_access_check (
	// protection state
	input wire logic locked_i,
	input wire fpp_pkg::fpp_hwmode_t hw_mode_i,
	input wire logic [1:0] pe_en_i,
	// request
	input wire logic is_ext_i,
	input wire fpp_pkg::fpp_req_t req_i,
	// verdict
	output logic permit_o
);
	import fpp_pkg::*;

	logic pfl_prot;
	logic dfl_prot;
	logic tgt_prot;
	logic src_ok;
	logic is_read;

	assign pfl_prot = (hw_mode_i != FPP_HW_NONE);
	assign dfl_prot = (hw_mode_i == FPP_HW_MODE1);
	assign is_read = (req_i.op == FPP_OP_READ);

	always_comb begin
		tgt_prot = 1'b0;
		src_ok = 1'b1;
		unique case (req_i.target)
			FPP_AREA_PFLASH: begin
				tgt_prot = pfl_prot;
				src_ok = (req_i.src == FPP_AREA_PFLASH) |
					(dfl_prot & (req_i.src == FPP_AREA_DFLASH));
			end
			FPP_AREA_DFLASH: begin
				tgt_prot = dfl_prot;
				src_ok = (req_i.src != FPP_AREA_OTHER);
			end
			default: begin
				tgt_prot = 1'b0;
				src_ok = 1'b1;
			end
		endcase
	end

	always_comb begin
		if (is_ext_i) begin
			permit_o = ~locked_i;
		end else if (req_i.target == FPP_AREA_OTHER) begin
			permit_o = 1'b1;
		end else if (is_read) begin
			permit_o = ~tgt_prot | src_ok;
		end else if (tgt_prot) begin
			permit_o = 1'b0;
		end else if (req_i.target == FPP_AREA_PFLASH) begin
			permit_o = pe_en_i[`FPP_MODE_PFL_PE];
		end else begin
			permit_o = pe_en_i[`FPP_MODE_DFL_PE];
		end
	end

endmodule

/* File: verilog/fpp_top.sv */
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "fpp_cfg.svh"

module fpp_top (
	// clock and reset
	input wire logic MCLK_I,
	input wire logic RST_I,
	// register port
	input wire logic [7:0] REG_ADDR_I,
	input wire logic [7:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	output logic [7:0] REG_RDATA_O,
	// boot loader and stored password
	input wire logic BL_PROG_I,
	input wire logic [3:0] BL_MODE_I,
	input wire logic [15:0] BL_PWD_I,
	input wire logic [15:0] PWD_NV_I,
	// protection state
	output logic PWD_VALID_O,
	output fpp_pkg::fpp_hwmode_t HW_MODE_O,
	// cpu accesses
	input wire logic CPU_VALID_I,
	input wire fpp_pkg::fpp_req_t CPU_REQ_I,
	output logic CPU_DONE_O,
	output logic CPU_DENY_O,
	output logic [7:0] CPU_RDATA_O,
	// external accesses
	input wire logic EXT_VALID_I,
	input wire fpp_pkg::fpp_req_t EXT_REQ_I,
	output logic EXT_DONE_O,
	output logic EXT_DENY_O,
	output logic EXT_BUSY_O,
	output logic [7:0] EXT_RDATA_O,
	// flash array
	output logic FLASH_VALID_O,
	output fpp_pkg::fpp_req_t FLASH_CMD_O,
	input wire logic [7:0] FLASH_RDATA_I
);
	import fpp_pkg::*;

	// password store
	logic [15:0] pwd_ff;
	logic loaded_ff;
	logic pwd_ok;
	logic locked;
	logic bl_install;
	fpp_hwmode_t hw_mode;

	// password register fields
	logic [1:0] mode_ff;
	logic prot_s_ff;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;

	// access verdicts
	logic cpu_permit;
	logic ext_permit;
	logic cpu_grant;
	logic ext_grant;

	// stage one
	logic cpu_s1_ff;
	logic cpu_deny_s1_ff;
	logic cpu_rd_s1_ff;
	logic ext_s1_ff;
	logic ext_deny_s1_ff;
	logic ext_busy_s1_ff;
	logic ext_rd_s1_ff;
	logic flash_valid_ff;
	fpp_req_t flash_cmd_ff;

	// stage two
	logic cpu_done_ff;
	logic cpu_deny_ff;
	logic [7:0] cpu_rdata_ff;
	logic ext_done_ff;
	logic ext_deny_ff;
	logic ext_busy_ff;
	logic [7:0] ext_rdata_ff;
	logic valid_ff;
	fpp_hwmode_t hw_mode_ff;

	assign pwd_ok = (pwd_ff != `FPP_PWD_NONE);
	// until the stored password is in, the device must count as locked
	assign locked = pwd_ok | ~loaded_ff;
	assign hw_mode = pwd_ok ? fpp_decode_hw(pwd_ff) : FPP_HW_NONE;

	assign bl_install = BL_PROG_I &
		(BL_MODE_I == `FPP_BL_MODE_INSTALL) &
		(BL_PWD_I != `FPP_PWD_NONE) &
		loaded_ff &
		~pwd_ok;

	// stored password caught after reset release, then boot loader install
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			pwd_ff <= `FPP_PWD_NONE;
			loaded_ff <= 1'b0;
		end else if (!loaded_ff) begin
			pwd_ff <= PWD_NV_I;
			loaded_ff <= 1'b1;
		end else if (bl_install) begin
			pwd_ff <= BL_PWD_I;
		end
	end

	// mode field is the only writable part; pass entry is not stored
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			mode_ff <= `FPP_MODE_RST;
		end else if (REG_WR_I && REG_ADDR_I == `FPP_OFF_PWREG) begin
			mode_ff <= REG_WDATA_I[`FPP_MODE_MSB:`FPP_MODE_LSB];
		end
	end

	// status flag follows the password store, no software write
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			prot_s_ff <= `FPP_PROT_RST;
		end else begin
			prot_s_ff <= pwd_ok;
		end
	end

	always_comb begin
		nxt_rdata = 8'h00;
		if (REG_RD_I) begin
			unique case (REG_ADDR_I)
				`FPP_OFF_PWREG: begin
					nxt_rdata[`FPP_PASS_MSB:`FPP_PASS_LSB] = `FPP_PASS_RST;
					nxt_rdata[`FPP_PROT_BIT] = prot_s_ff;
					nxt_rdata[`FPP_MODE_MSB:`FPP_MODE_LSB] = mode_ff;
				end
				`FPP_OFF_STAT: begin
					nxt_rdata = {4'h0, loaded_ff, pwd_ok, hw_mode};
				end
				default: begin
					nxt_rdata = 8'h00;
				end
			endcase
		end
	end

	// read data stands one cycle only
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	fpp_access_check u_cpu_check (
		.locked_i(locked),
		.hw_mode_i(hw_mode),
		.pe_en_i(mode_ff),
		.is_ext_i(1'b0),
		.req_i(CPU_REQ_I),
		.permit_o(cpu_permit)
	);

	fpp_access_check u_ext_check (
		.locked_i(locked),
		.hw_mode_i(hw_mode),
		.pe_en_i(mode_ff),
		.is_ext_i(1'b1),
		.req_i(EXT_REQ_I),
		.permit_o(ext_permit)
	);

	// cpu has the flash port first; a refused cpu request leaves it free
	assign cpu_grant = CPU_VALID_I & cpu_permit;
	assign ext_grant = EXT_VALID_I & ext_permit & ~cpu_grant;

	// flash command; refused requests never reach the array
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			flash_valid_ff <= 1'b0;
			flash_cmd_ff <= '0;
		end else if (cpu_grant) begin
			flash_valid_ff <= 1'b1;
			flash_cmd_ff <= CPU_REQ_I;
		end else if (ext_grant) begin
			flash_valid_ff <= 1'b1;
			flash_cmd_ff <= EXT_REQ_I;
		end else begin
			flash_valid_ff <= 1'b0;
			flash_cmd_ff <= '0;
		end
	end

	// cpu stage one
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			cpu_s1_ff <= 1'b0;
			cpu_deny_s1_ff <= 1'b0;
			cpu_rd_s1_ff <= 1'b0;
		end else begin
			cpu_s1_ff <= CPU_VALID_I;
			cpu_deny_s1_ff <= CPU_VALID_I & ~cpu_permit;
			cpu_rd_s1_ff <= cpu_grant & (CPU_REQ_I.op == FPP_OP_READ);
		end
	end

	// external stage one
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			ext_s1_ff <= 1'b0;
			ext_deny_s1_ff <= 1'b0;
			ext_busy_s1_ff <= 1'b0;
			ext_rd_s1_ff <= 1'b0;
		end else begin
			ext_s1_ff <= EXT_VALID_I;
			ext_deny_s1_ff <= EXT_VALID_I & ~ext_permit;
			ext_busy_s1_ff <= EXT_VALID_I & ext_permit & cpu_grant;
			ext_rd_s1_ff <= ext_grant & (EXT_REQ_I.op == FPP_OP_READ);
		end
	end

	// cpu answer; same latency granted or not, so answers stay in order
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			cpu_done_ff <= 1'b0;
			cpu_deny_ff <= 1'b0;
			cpu_rdata_ff <= 8'h00;
		end else begin
			cpu_done_ff <= cpu_s1_ff;
			cpu_deny_ff <= cpu_deny_s1_ff;
			cpu_rdata_ff <= cpu_rd_s1_ff ? FLASH_RDATA_I : 8'h00;
		end
	end

	// external answer; refused or busy returns zero data
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			ext_done_ff <= 1'b0;
			ext_deny_ff <= 1'b0;
			ext_busy_ff <= 1'b0;
			ext_rdata_ff <= 8'h00;
		end else begin
			ext_done_ff <= ext_s1_ff;
			ext_deny_ff <= ext_deny_s1_ff;
			ext_busy_ff <= ext_busy_s1_ff;
			ext_rdata_ff <= ext_rd_s1_ff ? FLASH_RDATA_I : 8'h00;
		end
	end

	// protection state outputs
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			valid_ff <= 1'b0;
			hw_mode_ff <= FPP_HW_NONE;
		end else begin
			valid_ff <= pwd_ok;
			hw_mode_ff <= hw_mode;
		end
	end

	assign REG_RDATA_O = rdata_ff;
	assign PWD_VALID_O = valid_ff;
	assign HW_MODE_O = hw_mode_ff;
	assign CPU_DONE_O = cpu_done_ff;
	assign CPU_DENY_O = cpu_deny_ff;
	assign CPU_RDATA_O = cpu_rdata_ff;
	assign EXT_DONE_O = ext_done_ff;
	assign EXT_DENY_O = ext_deny_ff;
	assign EXT_BUSY_O = ext_busy_ff;
	assign EXT_RDATA_O = ext_rdata_ff;
	assign FLASH_VALID_O = flash_valid_ff;
	assign FLASH_CMD_O = flash_cmd_ff;

endmodule

/* File: dv/fpp_top_properties.sv */
`timescale 1ns/1ps
module fpp_top_chk
	import fpp_pkg::*;
(
	// watched ports
	input wire logic MCLK_I, RST_I, REG_RD_I, CPU_VALID_I, EXT_VALID_I,
	input wire logic CPU_DONE_O, CPU_DENY_O, EXT_DENY_O, FLASH_VALID_O, PWD_VALID_O,
	input wire logic [7:0] REG_ADDR_I, REG_RDATA_O, CPU_RDATA_O, EXT_RDATA_O,
	input wire fpp_pkg::fpp_hwmode_t HW_MODE_O,
	input wire fpp_pkg::fpp_req_t CPU_REQ_I
);
	wire logic rd_pf;
	assign rd_pf = CPU_VALID_I && CPU_REQ_I.op == FPP_OP_READ && CPU_REQ_I.target == FPP_AREA_PFLASH;
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (RST_I);
	a_ext_lock_deny: assert property (PWD_VALID_O && EXT_VALID_I |-> ##2 EXT_DENY_O)
		else $error("external access passed while locked");
	a_ext_no_flash: assert property (PWD_VALID_O && EXT_VALID_I && !CPU_VALID_I |=> !FLASH_VALID_O)
		else $error("locked external access reached flash");
	a_cpu_deny_data: assert property (CPU_DENY_O |-> CPU_RDATA_O == 8'h00)
		else $error("refused cpu access returned data");
	a_ext_deny_data: assert property (EXT_DENY_O |-> EXT_RDATA_O == 8'h00)
		else $error("refused external access returned data");
	a_mode_needs_pwd: assert property (HW_MODE_O != FPP_HW_NONE |-> PWD_VALID_O)
		else $error("hardware mode without password");
	a_mode0_read: assert property (rd_pf && HW_MODE_O == FPP_HW_MODE0
		&& CPU_REQ_I.src != FPP_AREA_PFLASH |-> ##2 CPU_DENY_O)
		else $error("mode 0 foreign read allowed");
	a_mode1_read: assert property (rd_pf && HW_MODE_O == FPP_HW_MODE1
		&& CPU_REQ_I.src == FPP_AREA_DFLASH |-> ##2 CPU_DONE_O && !CPU_DENY_O)
		else $error("mode 1 dflash read refused");
	a_plain_read: assert property (rd_pf && PWD_VALID_O && HW_MODE_O == FPP_HW_NONE
		|-> ##2 CPU_DONE_O && !CPU_DENY_O)
		else $error("unprotected read refused");
	a_hw_no_prog: assert property (CPU_VALID_I && CPU_REQ_I.op != FPP_OP_READ
		&& CPU_REQ_I.target == FPP_AREA_PFLASH && HW_MODE_O != FPP_HW_NONE |-> ##2 CPU_DENY_O)
		else $error("protected pflash altered");
	a_pass_reads_zero: assert property (REG_RD_I && REG_ADDR_I == 8'hBB
		|=> REG_RDATA_O[7:3] == 5'h00)
		else $error("password field readable");
	cover property (HW_MODE_O == FPP_HW_MODE1 && CPU_DONE_O);
	cover property (EXT_DENY_O);
	cover property ($rose(PWD_VALID_O));
endmodule

bind fpp_top fpp_top_chk u_fpp_top_chk (.MCLK_I(MCLK_I), .RST_I(RST_I), .REG_RD_I(REG_RD_I),
	.CPU_VALID_I(CPU_VALID_I), .EXT_VALID_I(EXT_VALID_I), .CPU_DONE_O(CPU_DONE_O),
	.CPU_DENY_O(CPU_DENY_O), .EXT_DENY_O(EXT_DENY_O), .FLASH_VALID_O(FLASH_VALID_O),
	.PWD_VALID_O(PWD_VALID_O), .REG_ADDR_I(REG_ADDR_I), .REG_RDATA_O(REG_RDATA_O),
	.CPU_RDATA_O(CPU_RDATA_O), .EXT_RDATA_O(EXT_RDATA_O), .HW_MODE_O(HW_MODE_O),
	.CPU_REQ_I(CPU_REQ_I));

/* File: dv/fpp_flash_model.sv */
`timescale 1ns/1ps
module fpp_flash_model
	import fpp_pkg::*;
(
	// array side
	input wire logic clk_i,
	input wire logic valid_i,
	input wire fpp_pkg::fpp_req_t cmd_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem [256];
	logic [7:0] last_ff;
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = i[7:0] ^ 8'h5A;
		end
		last_ff = 8'h00;
	end
	// no hold between commands: stale data must never look valid
	assign rdata_o = valid_i ? mem[cmd_i.addr[7:0]] : ~last_ff;
	always @(posedge clk_i) begin
		if (valid_i) begin
			last_ff <= rdata_o;
			if (cmd_i.op == FPP_OP_PROG) mem[cmd_i.addr[7:0]] <= cmd_i.wdata;
			if (cmd_i.op == FPP_OP_ERASE) mem[cmd_i.addr[7:0]] <= 8'hFF;
		end
	end
endmodule

/* File: dv/tb_fpp_top.sv */
`timescale 1ns/1ps
module tb_fpp_top;
	import fpp_pkg::*;
	localparam fpp_op_t RD = FPP_OP_READ;
	localparam fpp_op_t PG = FPP_OP_PROG;
	localparam fpp_op_t ER = FPP_OP_ERASE;
	localparam fpp_area_t PF = FPP_AREA_PFLASH;
	localparam fpp_area_t DF = FPP_AREA_DFLASH;
	localparam fpp_area_t OT = FPP_AREA_OTHER;
	logic MCLK_I, RST_I, REG_WR_I, REG_RD_I, BL_PROG_I, CPU_VALID_I, EXT_VALID_I;
	logic PWD_VALID_O, CPU_DONE_O, CPU_DENY_O, EXT_DONE_O, EXT_DENY_O, EXT_BUSY_O, FLASH_VALID_O;
	logic [7:0] REG_ADDR_I, REG_WDATA_I, REG_RDATA_O, CPU_RDATA_O, EXT_RDATA_O, FLASH_RDATA_I;
	logic [3:0] BL_MODE_I;
	logic [15:0] BL_PWD_I, PWD_NV_I;
	fpp_hwmode_t HW_MODE_O;
	fpp_req_t CPU_REQ_I, EXT_REQ_I, FLASH_CMD_O;
	int err_count = 0;
	int num_checks = 0;
	int cyc = 0;
	fpp_top u_fpp_top (.MCLK_I(MCLK_I), .RST_I(RST_I), .REG_ADDR_I(REG_ADDR_I),
		.REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
		.REG_RDATA_O(REG_RDATA_O), .BL_PROG_I(BL_PROG_I), .BL_MODE_I(BL_MODE_I),
		.BL_PWD_I(BL_PWD_I), .PWD_NV_I(PWD_NV_I), .PWD_VALID_O(PWD_VALID_O),
		.HW_MODE_O(HW_MODE_O), .CPU_VALID_I(CPU_VALID_I), .CPU_REQ_I(CPU_REQ_I),
		.CPU_DONE_O(CPU_DONE_O), .CPU_DENY_O(CPU_DENY_O), .CPU_RDATA_O(CPU_RDATA_O),
		.EXT_VALID_I(EXT_VALID_I), .EXT_REQ_I(EXT_REQ_I), .EXT_DONE_O(EXT_DONE_O),
		.EXT_DENY_O(EXT_DENY_O), .EXT_BUSY_O(EXT_BUSY_O), .EXT_RDATA_O(EXT_RDATA_O),
		.FLASH_VALID_O(FLASH_VALID_O), .FLASH_CMD_O(FLASH_CMD_O), .FLASH_RDATA_I(FLASH_RDATA_I));
	fpp_flash_model u_fpp_flash_model (.clk_i(MCLK_I), .valid_i(FLASH_VALID_O),
		.cmd_i(FLASH_CMD_O), .rdata_o(FLASH_RDATA_I));
	initial begin
		MCLK_I = 1'b0;
		forever #2 MCLK_I = ~MCLK_I;
	end
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task complete_run;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// hang guard, run needs under a hundred cycles
	always @(posedge MCLK_I) begin
		cyc++;
		if (cyc > 2000) begin
			err_count++;
			complete_run();
		end
	end
	task rst(input logic [15:0] nv);
		if ($time > 0) begin
			@(posedge MCLK_I);
		end
		RST_I <= 1'b1;
		PWD_NV_I <= nv;
		repeat (2) @(posedge MCLK_I);
		RST_I <= 1'b0;
		repeat (3) @(posedge MCLK_I);
		#1;
	endtask
	task wr(input logic [7:0] a, d);
		@(posedge MCLK_I);
		REG_WR_I <= 1'b1;
		REG_ADDR_I <= a;
		REG_WDATA_I <= d;
		@(posedge MCLK_I);
		REG_WR_I <= 1'b0;
	endtask
	task rd(input logic [7:0] a, e);
		@(posedge MCLK_I);
		REG_RD_I <= 1'b1;
		REG_ADDR_I <= a;
		@(posedge MCLK_I);
		REG_RD_I <= 1'b0;
		#1;
		chk("reg", e, REG_RDATA_O);
	endtask
	task bl(input logic [3:0] m, input logic [15:0] p);
		@(posedge MCLK_I);
		BL_PROG_I <= 1'b1;
		BL_MODE_I <= m;
		BL_PWD_I <= p;
		@(posedge MCLK_I);
		BL_PROG_I <= 1'b0;
		repeat (2) @(posedge MCLK_I);
		#1;
	endtask
	task acc(input bit x, fpp_op_t o, fpp_area_t s, fpp_area_t t, logic [7:0] a, d,
		logic dn, logic [7:0] ed);
		@(posedge MCLK_I);
		CPU_VALID_I <= !x;
		EXT_VALID_I <= x;
		CPU_REQ_I <= '{o, s, t, {8'h00, a}, d};
		EXT_REQ_I <= '{o, s, t, {8'h00, a}, d};
		@(posedge MCLK_I);
		CPU_VALID_I <= 1'b0;
		EXT_VALID_I <= 1'b0;
		#1;
		chk("flash valid", !dn, FLASH_VALID_O);
		chk("flash addr", dn ? 16'h0000 : {8'h00, a}, FLASH_CMD_O.addr);
		@(posedge MCLK_I);
		#1;
		chk("done", 16'h1, x ? EXT_DONE_O : CPU_DONE_O);
		chk("deny", dn, x ? EXT_DENY_O : CPU_DENY_O);
		chk("rdata", ed, x ? EXT_RDATA_O : CPU_RDATA_O);
	endtask
	// cpu and external read in one cycle: cpu keeps the port
	task race(input logic [7:0] a, ed);
		@(posedge MCLK_I);
		CPU_VALID_I <= 1'b1;
		EXT_VALID_I <= 1'b1;
		CPU_REQ_I <= '{RD, PF, PF, {8'h00, a}, 8'h00};
		EXT_REQ_I <= '{RD, OT, PF, {8'h00, a}, 8'h00};
		@(posedge MCLK_I);
		CPU_VALID_I <= 1'b0;
		EXT_VALID_I <= 1'b0;
		@(posedge MCLK_I);
		#1;
		chk("ext busy", 16'h1, EXT_BUSY_O);
		chk("ext done", 16'h1, EXT_DONE_O);
		chk("ext rdata", 16'h0, EXT_RDATA_O);
		chk("cpu rdata", ed, CPU_RDATA_O);
	endtask
	initial begin
		{REG_WR_I, REG_RD_I, REG_ADDR_I, REG_WDATA_I, BL_PROG_I, BL_MODE_I, BL_PWD_I} = '0;
		{CPU_VALID_I, EXT_VALID_I, CPU_REQ_I, EXT_REQ_I} = '0;
		RST_I = 1'b1;
		rst(16'hFFFF);
		rd(8'hBB, 8'h03);
		wr(8'hBB, 8'hFC);
		rd(8'hBB, 8'h00);
		wr(8'hBB, 8'h03);
		rd(8'h10, 8'h00);
		acc(1, RD, OT, PF, 8'h10, 8'h00, 0, 8'h4A);
		acc(0, RD, OT, PF, 8'h11, 8'h00, 0, 8'h4B);
		acc(0, PG, PF, PF, 8'h12, 8'h3C, 0, 8'h00);
		race(8'h13, 8'h49);
		bl(4'h5, 16'h2000);
		chk("valid", 16'h0, PWD_VALID_O);
		bl(4'h6, 16'hFFFF);
		chk("valid", 16'h0, PWD_VALID_O);
		bl(4'h6, 16'h2000);
		chk("valid", 16'h1, PWD_VALID_O);
		chk("mode", FPP_HW_MODE0, HW_MODE_O);
		rd(8'hBB, 8'h07);
		acc(1, RD, OT, PF, 8'h10, 8'h00, 1, 8'h00);
		acc(1, PG, OT, PF, 8'h12, 8'hFF, 1, 8'h00);
		acc(1, RD, OT, DF, 8'h20, 8'h00, 1, 8'h00);
		acc(0, RD, DF, PF, 8'h12, 8'h00, 1, 8'h00);
		acc(0, RD, PF, PF, 8'h12, 8'h00, 0, 8'h3C);
		acc(0, RD, OT, DF, 8'h20, 8'h00, 0, 8'h7A);
		acc(0, PG, PF, PF, 8'h12, 8'h00, 1, 8'h00);
		rst(16'hA000);
		chk("mode", FPP_HW_MODE1, HW_MODE_O);
		acc(0, RD, DF, PF, 8'h11, 8'h00, 0, 8'h4B);
		acc(0, RD, OT, PF, 8'h11, 8'h00, 1, 8'h00);
		acc(0, RD, OT, DF, 8'h20, 8'h00, 1, 8'h00);
		acc(0, ER, PF, DF, 8'h20, 8'h00, 1, 8'h00);
		rst(16'h0001);
		chk("mode", FPP_HW_NONE, HW_MODE_O);
		acc(1, RD, OT, PF, 8'h11, 8'h00, 1, 8'h00);
		acc(0, RD, OT, PF, 8'h11, 8'h00, 0, 8'h4B);
		complete_run();
	end
endmodule
